// ===== hdl/ucr_pkg.sv
// Package with register layout and constants for the USB clock/reset control block
package ucr_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] UCR_ADDR_CTRL = 4'h0; // Control/status word
  localparam logic [3:0] UCR_ADDR_MASK = 4'h4; // Interrupt mask word
  localparam logic [31:0] UCR_RD_UNMAPPED = 32'h0000_0000; // Unmapped read value
  // ==========================================================
  // Field positions
  localparam int UCR_B_IF = 26; // Bus event flag
  localparam int UCR_B_RF = 25; // Resume flag
  localparam int UCR_B_WK = 24; // Activity status
  localparam int UCR_B_RSV1 = 15; // Reserved, reads one
  localparam int UCR_B_IDOV = 9; // Id override enable
  localparam int UCR_B_IDVAL = 8; // Id override value
  localparam int UCR_B_PHYID = 7; // Phy id monitor enable
  localparam int UCR_B_VBUS = 6; // Vbus valid monitor enable
  localparam int UCR_B_ASV = 5; // A session monitor enable
  localparam int UCR_B_BSV = 4; // B session monitor enable
  localparam int UCR_B_SEND = 3; // Session end monitor enable
  localparam int UCR_B_IE = 2; // Bus event irq enable
  localparam int UCR_B_RIE = 1; // Resume irq enable
  localparam int UCR_B_WKE = 0; // Activity wake enable
  localparam int UCR_NEV = 3; // Number of event flags
  // ==========================================================
  // Reset values
  localparam logic [9:0] UCR_CTRL_RST = 10'h000; // Writable low bits 9..0
  localparam logic [2:0] UCR_EV_RST = 3'h1; // Activity status resets to one
  localparam logic [2:0] UCR_MASK_RST = 3'h0; // Mask reset
  // ==========================================================
  // Bus slave states
  typedef enum logic [0:0] {UCR_IDLE, UCR_DONE} ucr_bus_t;
endpackage

// ===== hdl/ucr_sync.sv
// Two-flop synchroniser bank for PHY status inputs
`timescale 1ns/1ps
`default_nettype none
module ucr_sync #(
  parameter int W = 4
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================================
  // Synchroniser chain
  logic [W-1:0] s1_r; // First stage, read only by second
  logic [W-1:0] s2_r; // Second stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Per-bit two-flop chain
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= d_i[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate
  assign q_o = s2_r;
endmodule
`default_nettype wire

// ===== hdl/ucr_top.sv
// USB clock/reset control register with event flags, id override and monitor enables
//
// Behaviour
// - Bus event sets general flag bit 26 when enable bit 2 is set
// - Resume during suspend sets flag bit 25
// - Bus activity sets sticky status bit 24
// - Override enable selects programmed or PHY id
// - Bit 8 gives override id value
// - Bit 7 gates PHY id monitoring
// - Bit 6 gates VBUS valid monitoring
// - Bit 5 gates A session monitoring
// - Bit 4 gates B session monitoring
// - Bit 15 reads one, unused bits zero
`timescale 1ns/1ps
`default_nettype none
module ucr_top
  import ucr_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Event pulses and suspend level from the USB core
  input wire logic bus_event_i,
  input wire logic resume_i,
  input wire logic activity_i,
  input wire logic suspended_i,
  // PHY status pins
  input wire logic phy_id_i,
  input wire logic phy_vbus_valid_i,
  input wire logic phy_a_session_i,
  input wire logic phy_b_session_i,
  input wire logic phy_session_end_i,
  // Towards OTG logic
  output logic otg_id_o,
  output logic id_monitored_o,
  output logic vbus_valid_o,
  output logic a_session_o,
  output logic b_session_o,
  output logic session_end_o,
  output logic irq_o
);
  // ==========================================================
  // Declarations
  logic [4:0] phy_s; // Synchronised PHY pins
  logic [9:0] ctrl_r; // Writable control bits 9..0
  logic [9:0] ctrl_nxt;
  logic [2:0] ev_r; // Sticky flags: {if, rf, wk}
  logic [2:0] ev_nxt;
  logic [2:0] mask_r; // Interrupt mask
  logic [2:0] mask_nxt;
  logic [2:0] ev_set; // Hardware set terms
  logic [2:0] ev_clr; // Software clear terms
  logic [2:0] ev_en; // Per-flag enables from low byte
  logic [5:0] out_r; // Registered OTG outputs
  logic [5:0] out_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] ctrl_word; // Assembled control word
  ucr_bus_t st_r; // Bus slave state
  ucr_bus_t st_nxt;
  logic irq_r;
  logic irq_nxt;
  logic req; // Access pending
  logic wr_ctrl; // Write to control, any byte lanes
  logic wr_ctrl_hi; // Write to control, top lane
  logic wr_mask;

  // ==========================================================
  // PHY pin synchronisers
  ucr_sync #(.W(5)) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .d_i({phy_session_end_i, phy_b_session_i, phy_a_session_i, phy_vbus_valid_i, phy_id_i}),
    .q_o(phy_s)
  );

  // ==========================================================
  // Bus decode
  // Writes commit at the edge where waitrequest is seen low, in the answer cycle
  assign req = (avs_read_i | avs_write_i) & (st_r == UCR_DONE);
  assign wr_ctrl = req & avs_write_i & (avs_address_i == UCR_ADDR_CTRL);
  assign wr_ctrl_hi = wr_ctrl & avs_byteenable_i[3];
  assign wr_mask = req & avs_write_i & (avs_address_i == UCR_ADDR_MASK) & avs_byteenable_i[0];
  // Wait one cycle, answer in the second
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (st_r == UCR_IDLE);

  // ==========================================================
  // Control word assembly
  always_comb begin
    ctrl_word = 32'h0000_0000; // Unimplemented bits read zero
    ctrl_word[UCR_B_IF] = ev_r[2];
    ctrl_word[UCR_B_RF] = ev_r[1];
    ctrl_word[UCR_B_WK] = ev_r[0];
    ctrl_word[UCR_B_RSV1] = 1'b1; // Reserved reads one
    ctrl_word[UCR_B_IDOV:0] = ctrl_r;
  end

  // ==========================================================
  // Next state: control, flags, mask, bus
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    st_nxt = st_r;
    rdata_nxt = rdata_r;
    ev_en = {ctrl_r[UCR_B_IE], ctrl_r[UCR_B_RIE], ctrl_r[UCR_B_WKE]};
    // Hardware sets
    ev_set[2] = bus_event_i & ctrl_r[UCR_B_IE];
    ev_set[1] = resume_i & suspended_i;
    ev_set[0] = activity_i;
    // Write one to clear on the flag bits
    ev_clr = wr_ctrl_hi ? avs_writedata_i[UCR_B_IF:UCR_B_WK] : 3'h0;
    ev_nxt = (ev_r & ~ev_clr) | ev_set; // Set wins over clear
    if (wr_ctrl & avs_byteenable_i[0]) begin
      ctrl_nxt[7:0] = avs_writedata_i[7:0];
    end
    if (wr_ctrl & avs_byteenable_i[1]) begin
      ctrl_nxt[UCR_B_IDOV:UCR_B_IDVAL] = avs_writedata_i[UCR_B_IDOV:UCR_B_IDVAL];
    end
    if (wr_mask) begin
      mask_nxt = avs_writedata_i[UCR_NEV-1:0];
    end
    unique case (st_r)
      UCR_IDLE: begin
        if (avs_read_i | avs_write_i) begin
          st_nxt = UCR_DONE;
          if (avs_address_i == UCR_ADDR_CTRL) begin
            rdata_nxt = ctrl_word;
          end else if (avs_address_i == UCR_ADDR_MASK) begin
            rdata_nxt = {29'h0000_0000, mask_r};
          end else begin
            rdata_nxt = UCR_RD_UNMAPPED;
          end
        end
      end
      UCR_DONE: begin
        st_nxt = UCR_IDLE;
      end
    endcase
    // Forward flags only when enabled and unmasked
    irq_nxt = |(ev_r & ev_en & mask_r);
  end

  // ==========================================================
  // OTG side outputs
  always_comb begin
    out_nxt[0] = ctrl_r[UCR_B_IDOV] ? ctrl_r[UCR_B_IDVAL] : phy_s[0];
    out_nxt[1] = ctrl_r[UCR_B_PHYID] & phy_s[0];
    out_nxt[2] = ctrl_r[UCR_B_VBUS] & phy_s[1];
    out_nxt[3] = ctrl_r[UCR_B_ASV] & phy_s[2];
    out_nxt[4] = ctrl_r[UCR_B_BSV] & phy_s[3];
    out_nxt[5] = ctrl_r[UCR_B_SEND] & phy_s[4];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= UCR_CTRL_RST;
      ev_r <= UCR_EV_RST;
      mask_r <= UCR_MASK_RST;
      st_r <= UCR_IDLE;
      rdata_r <= 32'h0000_0000;
      out_r <= 6'h00;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ev_r <= ev_nxt;
      mask_r <= mask_nxt;
      st_r <= st_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign otg_id_o = out_r[0];
  assign id_monitored_o = out_r[1];
  assign vbus_valid_o = out_r[2];
  assign a_session_o = out_r[3];
  assign b_session_o = out_r[4];
  assign session_end_o = out_r[5];
  assign irq_o = irq_r;

  // ==========================================================
  // Assertions
  AST_IF_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bus_event_i & ctrl_r[UCR_B_IE] |=> ev_r[2]) else $error("bus event flag not set");
  AST_RF_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    resume_i & suspended_i |=> ev_r[1]) else $error("resume flag not set");
  AST_RF_NOSUSP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ev_r[1] & !(resume_i & suspended_i) |=> !ev_r[1]) else $error("resume flag set spuriously");
  AST_WK_STICKY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ev_r[0] & !wr_ctrl_hi |=> ev_r[0]) else $error("activity status lost");
  AST_WK_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    activity_i |=> ev_r[0]) else $error("activity not flagged");
  AST_ID_OVR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ctrl_r[UCR_B_IDOV] |=> otg_id_o == $past(ctrl_r[UCR_B_IDVAL])) else $error("override id wrong");
  AST_ID_PHY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ctrl_r[UCR_B_IDOV] |=> otg_id_o == $past(phy_s[0])) else $error("phy id not used");
  AST_MON_OFF: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ctrl_r[UCR_B_PHYID] & !ctrl_r[UCR_B_VBUS] ##1 1'b1 |-> !id_monitored_o & !vbus_valid_o)
    else $error("monitor active while off");
  AST_ASV: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ctrl_r[UCR_B_ASV] |=> !a_session_o) else $error("a session monitor on");
  AST_BSV: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ctrl_r[UCR_B_BSV] |=> !b_session_o) else $error("b session monitor on");
  AST_RSV: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_r == UCR_DONE && $past(avs_read_i && avs_address_i == UCR_ADDR_CTRL)
    |-> avs_readdata_o[UCR_B_RSV1] && avs_readdata_o[23:16] == 8'h00) else $error("reserved bits wrong");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(|(ev_r & ev_en & mask_r)) |=> !irq_o) else $error("irq without enabled flag");
  AST_VBUS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !ctrl_r[UCR_B_VBUS] ##1 !ctrl_r[UCR_B_VBUS] |-> !vbus_valid_o) else $error("vbus monitor on");
  COV_IRQ: cover property (@(posedge clock_i) disable iff (sys_rst_i) $rose(irq_o));
  COV_CLR: cover property (@(posedge clock_i) disable iff (sys_rst_i) ev_r[0] ##1 !ev_r[0]);
  COV_OVR: cover property (@(posedge clock_i) disable iff (sys_rst_i) ctrl_r[UCR_B_IDOV] & otg_id_o);
  COV_RD: cover property (@(posedge clock_i) disable iff (sys_rst_i) avs_read_i & !avs_waitrequest_o);
endmodule
`default_nettype wire

// ===== sim/ucr_core_model.sv
// Behavioural model of the USB core and PHY facing the control block
`timescale 1ns/1ps
`default_nettype none
module ucr_core_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] fire_i,
  input wire logic suspend_i,
  input wire logic [4:0] pins_i,
  output logic bus_event_o,
  output logic resume_o,
  output logic activity_o,
  output logic suspended_o,
  output logic [4:0] pins_o
);
  // ==========================================================
  // Core events launched just after the edge, one cycle wide
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {bus_event_o, resume_o, activity_o, suspended_o} <= 4'h0;
      pins_o <= 5'h00;
    end else begin
      {bus_event_o, resume_o, activity_o} <= fire_i; // Single pulses
      suspended_o <= suspend_i; // Link suspend level
      pins_o <= pins_i; // Levels {id, vbus, a, b, send}
    end
  end
endmodule
`default_nettype wire

// ===== sim/usb_clock_reset_control_bench.sv
// Self-checking bench for the USB clock/reset control register
`timescale 1ns/1ps
`default_nettype none
module usb_clock_reset_control_bench;
  import ucr_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [2:0] fire = 3'h0;
  logic susp = 1'b0;
  logic [4:0] pins = 5'h00;
  logic bev, res, act, sus, otg_id, id_mon, irq;
  logic [4:0] pm;
  logic [3:0] mon;
  int num_errors = 0;
  int check_count = 0;
  always #2 clock_i = ~clock_i; // 250 MHz
  ucr_core_model u_ucr_core_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fire_i(fire), .suspend_i(susp),
    .pins_i(pins), .bus_event_o(bev), .resume_o(res), .activity_o(act), .suspended_o(sus), .pins_o(pm));
  ucr_top u_ucr_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .bus_event_i(bev), .resume_i(res), .activity_i(act), .suspended_i(sus),
    .phy_id_i(pm[4]), .phy_vbus_valid_i(pm[3]), .phy_a_session_i(pm[2]), .phy_b_session_i(pm[1]),
    .phy_session_end_i(pm[0]), .otg_id_o(otg_id), .id_monitored_o(id_mon), .vbus_valid_o(mon[3]),
    .a_session_o(mon[2]), .b_session_o(mon[1]), .session_end_o(mon[0]), .irq_o(irq));
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    be <= b;
    @(posedge clock_i);
    // Waitrequest sampled at the rising edge; request held until it is low
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(n < 50), 32'h1, "no bus answer");
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr32(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    xfer(1'b1, a, d, b, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, exp, "read word");
  endtask
  // Fire core events, then let flags settle
  task automatic pulse(input logic [2:0] f);
    @(posedge clock_i);
    fire <= f;
    @(posedge clock_i);
    fire <= 3'h0;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk({31'h0, irq}, {31'h0, exp}, "irq level");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(UCR_ADDR_CTRL, 32'h0100_8000);
    rd_chk(UCR_ADDR_MASK, 32'h0000_0000);
    wr32(4'h8, 32'hFFFF_FFFF, 4'hF); // Unmapped write is dropped
    rd_chk(4'h8, UCR_RD_UNMAPPED);
    wr32(UCR_ADDR_CTRL, 32'hFFFF_FFF8, 4'h3);
    rd_chk(UCR_ADDR_CTRL, 32'h0100_83F8);
    wr32(UCR_ADDR_CTRL, 32'h0000_0000, 4'h3);
  endtask
  // Override, id monitor and VBUS monitors over 32 combinations, two monitor enable patterns
  task automatic t_outputs;
    logic [9:0] ctl;
    logic [3:0] en;
    for (int k = 0; k < 32; k++) begin
      en = k[1] ? 4'hA : 4'h5;
      ctl = {k[4], k[3], k[2], en, 3'h0};
      wr32(UCR_ADDR_CTRL, {22'h0, ctl}, 4'h3);
      @(posedge clock_i);
      pins <= {k[0], k[0] ? 4'h6 : 4'h9};
      repeat (6) @(posedge clock_i);
      @(negedge clock_i);
      chk({31'h0, otg_id}, {31'h0, k[4] ? k[3] : k[0]}, "otg id");
      chk({31'h0, id_mon}, {31'h0, k[2] & k[0]}, "id monitor");
      chk({28'h0, mon}, {28'h0, en & (k[0] ? 4'h6 : 4'h9)}, "vbus monitors");
    end
    wr32(UCR_ADDR_CTRL, 32'h0000_0000, 4'h3);
  endtask
  task automatic t_events;
    wr32(UCR_ADDR_CTRL, 32'h0100_0000, 4'h8); // Clear activity before sleep
    rd_chk(UCR_ADDR_CTRL, 32'h0000_8000);
    pulse(3'b001);
    rd_chk(UCR_ADDR_CTRL, 32'h0100_8000);
    rd_chk(UCR_ADDR_CTRL, 32'h0100_8000);
    pulse(3'b100); // Bus event while its enable is off
    rd_chk(UCR_ADDR_CTRL, 32'h0100_8000);
    wr32(UCR_ADDR_CTRL, 32'h0000_0004, 4'h1);
    pulse(3'b100);
    rd_chk(UCR_ADDR_CTRL, 32'h0500_8004);
    pulse(3'b010); // Resume while not suspended
    rd_chk(UCR_ADDR_CTRL, 32'h0500_8004);
    susp <= 1'b1;
    pulse(3'b010);
    rd_chk(UCR_ADDR_CTRL, 32'h0700_8004);
    wr32(UCR_ADDR_CTRL, 32'h0700_0000, 4'h8);
    rd_chk(UCR_ADDR_CTRL, 32'h0000_8004);
  endtask
  // Each flag alone through the mask, then cleared
  task automatic t_irq;
    wr32(UCR_ADDR_CTRL, 32'h0000_0007, 4'h1);
    pulse(3'b111);
    irq_chk(1'b0);
    for (int i = 0; i < 3; i++) begin
      wr32(UCR_ADDR_MASK, 32'(1 << i), 4'h1);
      irq_chk(1'b1);
      wr32(UCR_ADDR_CTRL, 32'(1 << (24 + i)) | 32'h7, 4'h9);
      irq_chk(1'b0);
    end
    pulse(3'b111);
    wr32(UCR_ADDR_MASK, 32'h0000_0007, 4'h1);
    irq_chk(1'b1);
    wr32(UCR_ADDR_CTRL, 32'h0000_0000, 4'h1);
    irq_chk(1'b0);
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_outputs;
    t_events;
    t_irq;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
